// ===== dac_ctrl_map.svh
// Functional notes
// R1: Ladder source is supply rail, buffered pin, or unbuffered pin, via two-bit select.
// R2: Supply reset events copy stored source-select bits into the volatile ones.
// R3: With the supply rail chosen, the reference pin stays off the ladder.
// R4: Controller choosing the pin source also chooses buffered or unbuffered mode.
// R5: Volatile code sets the wiper; ladder has 2^n elements, top code 2^n-1.
// R6: At full scale one element remains between wiper and ladder top.
// R7: Any power-down mode disconnects the ladder from its reference.
// R8: Every power-down mode turns the amplifier off, output high impedance.
// R9: Gain bit applies only with pin reference; supply rail means unity gain.
// R10: Volatile gain changes only by supply resets, writes, or general-call reset.
// R11: Code is unsigned; output follows code plus the five configuration bits.
// R12: New code is taken at the falling edge ending the last byte's acknowledge.
// R13: Power-on or general-call reset reloads output state from stored values.
// R14: Falling supply forces power-down '11', code zero, source and gain cleared.
// R15: Rising supply sets the reset flag; serial access waits for the delay timer.
// R16: General-call reset also reloads power-down and source-select bits.
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH
`define OFF_CTRL      8'h00
`define OFF_CODE      8'h04
`define OFF_NV_CTRL   8'h08
`define OFF_NV_CODE   8'h0c
`define OFF_STATUS    8'h10
`define OFF_CMD       8'h14
`define CTRL_PD_LSB   0
`define CTRL_SRC_LSB  2
`define CTRL_GAIN_BIT 4
`define STAT_POR_BIT  0
`define STAT_RDY_BIT  1
`define STAT_PEND_BIT 2
`define CMD_GC_BIT    0
`define PD_ALL_OFF    2'h3
`define PD_NORMAL     2'h0
`define NV_PD_RST     2'h0
`define NV_SRC_RST    2'h0
`define NV_GAIN_RST   1'h0
`define POR_DELAY_DEF 1000
`endif

// ===== dac_ctrl_pkg.sv
package dac_ctrl_pkg;
    typedef enum logic [1:0] {
        SRC_VDD       = 2'b00,
        SRC_VDD_ALT   = 2'b01,
        SRC_PIN_UNBUF = 2'b10,
        SRC_PIN_BUF   = 2'b11
    } ladder_source_t;
    typedef enum logic [1:0] {
        SUP_DOWN  = 2'b00,
        SUP_WAIT  = 2'b01,
        SUP_READY = 2'b10
    } supply_state_t;
endpackage : dac_ctrl_pkg

// ===== pin_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= '0;
            pin_sync <= '0;
        end else begin
            meta_q   <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule : pin_sync2
`default_nettype wire

// ===== dac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_map.svh"
module dac_ctrl
    import dac_ctrl_pkg::*;
#(
    parameter int          RES_BITS         = 12,
    parameter int unsigned POR_DELAY_CYCLES = `POR_DELAY_DEF
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    input  wire logic                supply_ok_pin,
    input  wire logic                scl_pin,
    output var  logic [RES_BITS-1:0] ladder_code,
    output var  logic                ladder_connect,
    output var  logic                ladder_src_vdd,
    output var  logic                ladder_src_pin_buf,
    output var  logic                ladder_src_pin_unbuf,
    output var  logic                amp_enable,
    output var  logic                amp_gain2,
    output var  logic [1:0]          powerdown_load_select,
    output var  logic                serial_ready
);
    function automatic logic src_is_pin(input logic [1:0] s);
        return (s == SRC_PIN_BUF) || (s == SRC_PIN_UNBUF);
    endfunction : src_is_pin

    logic                sup_ok_s;
    logic                scl_s;
    logic                scl_prev_q;
    supply_state_t       st_q;
    logic [31:0]         timer_q;
    logic [RES_BITS-1:0] code_q, nv_code_q, stg_code_q;
    logic [1:0]          pd_q, nv_pd_q, stg_pd_q;
    logic [1:0]          src_q, nv_src_q, stg_src_q;
    logic                gain_q, nv_gain_q, stg_gain_q;
    logic                pend_q;
    logic                por_flag_q;

    pin_sync2 #(.WIDTH(2)) pin_sync2_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   ({supply_ok_pin, scl_pin}),
        .pin_sync ({sup_ok_s, scl_s})
    );

    // Register decode and event qualification.
    wire ready_w  = (st_q == SUP_READY);
    wire acc_w    = psel & penable & pready;
    wire wr_w     = acc_w & pwrite;
    wire setup_w  = psel & ~penable & ~pready;
    wire sel_ctrl = (paddr == `OFF_CTRL);
    wire sel_code = (paddr == `OFF_CODE);
    wire sel_nvc  = (paddr == `OFF_NV_CTRL);
    wire sel_nvd  = (paddr == `OFF_NV_CODE);
    wire sel_stat = (paddr == `OFF_STATUS);
    wire sel_cmd  = (paddr == `OFF_CMD);
    wire mapped   = sel_ctrl | sel_code | sel_nvc | sel_nvd | sel_stat
                  | sel_cmd;
    wire scl_fall = scl_prev_q & ~scl_s;

    wire bor_w    = ~sup_ok_s;
    wire por_w    = sup_ok_s & (st_q == SUP_DOWN);
    wire gc_w     = sup_ok_s & ready_w & wr_w & sel_cmd
                  & pwdata[`CMD_GC_BIT];
    wire commit_w = sup_ok_s & ~por_w & ~gc_w & pend_q & scl_fall;
    wire reload_w = por_w | gc_w;
    wire stg_ctrl = ready_w & wr_w & sel_ctrl;
    wire stg_code = ready_w & wr_w & sel_code;
    wire nv_ctrl  = ready_w & wr_w & sel_nvc;
    wire nv_code  = ready_w & wr_w & sel_nvd;
    wire por_clr  = wr_w & sel_stat & pwdata[`STAT_POR_BIT];
    wire timer_done = (timer_q >= POR_DELAY_CYCLES - 1);

    wire [1:0] wr_pd   = pwdata[`CTRL_PD_LSB +: 2];
    wire [1:0] wr_src  = pwdata[`CTRL_SRC_LSB +: 2];
    wire       wr_gain = pwdata[`CTRL_GAIN_BIT];

    wire [31:0] ctrl_rd = 32'({gain_q, src_q, pd_q});
    wire [31:0] nvc_rd  = 32'({nv_gain_q, nv_src_q, nv_pd_q});
    wire [31:0] stat_rd = 32'({pend_q, ready_w, por_flag_q});
    wire [31:0] rdata_d = sel_ctrl ? ctrl_rd :
                          sel_code ? 32'(code_q) :
                          sel_nvc  ? nvc_rd :
                          sel_nvd  ? 32'(nv_code_q) :
                          sel_stat ? stat_rd : 32'h0000_0000;

    // Output decode from the volatile state.
    wire pd_on    = (pd_q != `PD_NORMAL);
    wire pin_src  = src_is_pin(src_q);
    wire conn_d   = ~pd_on;                                     // R7
    wire vdd_d    = ~pd_on & ~pin_src;                          // R1
    wire buf_d    = ~pd_on & (src_q == SRC_PIN_BUF);            // R1 R3
    wire unbuf_d  = ~pd_on & (src_q == SRC_PIN_UNBUF);          // R1 R3
    wire gain2_d  = gain_q & pin_src;                           // R9

    // Supply sequencing: a fall holds the block down, a rise starts the
    // delay before serial access opens.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= SUP_DOWN;
            timer_q <= 32'h0000_0000;
        end else begin
            case (st_q)
                SUP_DOWN: begin
                    timer_q <= 32'h0000_0000;
                    if (sup_ok_s) st_q <= SUP_WAIT;
                end
                SUP_WAIT: begin
                    timer_q <= timer_q + 32'h0000_0001;
                    if (bor_w) st_q <= SUP_DOWN;
                    else if (timer_done) st_q <= SUP_READY;     // R15
                end
                SUP_READY: begin
                    if (bor_w) st_q <= SUP_DOWN;
                end
                default: st_q <= SUP_DOWN;
            endcase
        end
    end

    // Volatile state. The supply fall outranks every other source; the
    // gain, code and configuration move on no other events.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_q   <= `PD_ALL_OFF;
            code_q <= '0;
            src_q  <= SRC_VDD;
            gain_q <= 1'b0;
        end else if (bor_w) begin                               // R14
            pd_q   <= `PD_ALL_OFF;
            code_q <= '0;
            src_q  <= SRC_VDD;
            gain_q <= 1'b0;
        end else if (reload_w) begin                            // R2 R13 R16
            pd_q   <= nv_pd_q;
            code_q <= nv_code_q;
            src_q  <= nv_src_q;
            gain_q <= nv_gain_q;                                // R10
        end else if (commit_w) begin                            // R12
            pd_q   <= stg_pd_q;
            code_q <= stg_code_q;                               // R5 R11
            src_q  <= stg_src_q;
            gain_q <= stg_gain_q;                               // R10
        end
    end

    // Staged write data waits for the acknowledge edge of the last byte.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stg_pd_q   <= `PD_NORMAL;
            stg_src_q  <= SRC_VDD;
            stg_gain_q <= 1'b0;
            stg_code_q <= '0;
        end else begin
            if (stg_ctrl) begin
                stg_pd_q   <= wr_pd;
                stg_src_q  <= wr_src;                           // R4
                stg_gain_q <= wr_gain;
            end
            if (stg_code) stg_code_q <= pwdata[RES_BITS-1:0];
        end
    end

    // A new staging write in the commit cycle keeps the update pending.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (bor_w || reload_w) begin
            pend_q <= 1'b0;
        end else if (stg_ctrl || stg_code) begin
            pend_q <= 1'b1;
        end else if (commit_w) begin
            pend_q <= 1'b0;
        end
    end

    // Stored image; it survives supply events, so only presetn clears it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_pd_q   <= `NV_PD_RST;
            nv_src_q  <= `NV_SRC_RST;
            nv_gain_q <= `NV_GAIN_RST;
            nv_code_q <= '0;
        end else begin
            if (nv_ctrl) begin
                nv_pd_q   <= wr_pd;
                nv_src_q  <= wr_src;
                nv_gain_q <= wr_gain;
            end
            if (nv_code) nv_code_q <= pwdata[RES_BITS-1:0];
        end
    end

    // Reset flag: a rising supply sets it and the set beats a clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_flag_q <= 1'b0;
        end else if (por_w) begin                               // R15
            por_flag_q <= 1'b1;
        end else if (por_clr) begin
            por_flag_q <= 1'b0;
        end
    end

    // The synchroniser leaves reset low, so the edge detector starts low
    // too; a high start would see a false falling edge after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_prev_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_s;
        end
    end

    // The bus answers with no wait state; pready rises in the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_w;
            pslverr <= setup_w & ~mapped;
            if (setup_w) prdata <= rdata_d;
        end
    end

    // Code drives the tap directly; no code reaches 2^n, so one element
    // always stays above the wiper.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_code           <= '0;
            ladder_connect        <= 1'b0;
            ladder_src_vdd        <= 1'b0;
            ladder_src_pin_buf    <= 1'b0;
            ladder_src_pin_unbuf  <= 1'b0;
            amp_enable            <= 1'b0;
            amp_gain2             <= 1'b0;
            powerdown_load_select <= `PD_ALL_OFF;
            serial_ready          <= 1'b0;
        end else begin
            ladder_code           <= code_q;                    // R5 R6
            ladder_connect        <= conn_d;                    // R7
            ladder_src_vdd        <= vdd_d;
            ladder_src_pin_buf    <= buf_d;
            ladder_src_pin_unbuf  <= unbuf_d;
            amp_enable            <= ~pd_on;                    // R8
            amp_gain2             <= gain2_d;                   // R9
            powerdown_load_select <= pd_q;
            serial_ready          <= ready_w;                   // R15
        end
    end

    sequence s_ack_commit;
        pend_q && scl_fall && sup_ok_s && !por_w && !gc_w;
    endsequence

    a_bor_forces_off: assert property (@(posedge pclk) disable iff (!presetn) // R14
        bor_w |=> pd_q == `PD_ALL_OFF && code_q == '0 && src_q == SRC_VDD
                  && !gain_q ##1 !amp_enable && !ladder_connect)
        else $error("supply fall did not force power-down");
    a_reload_source: assert property (@(posedge pclk) disable iff (!presetn) // R2
        por_w |=> src_q == $past(nv_src_q) && pd_q == $past(nv_pd_q))
        else $error("supply rise did not reload source select");
    a_vdd_pin_off: assert property (@(posedge pclk) disable iff (!presetn) // R3
        !src_is_pin(src_q) |=> !ladder_src_pin_buf && !ladder_src_pin_unbuf)
        else $error("reference pin tied to ladder with rail source");
    a_pd_ladder_off: assert property (@(posedge pclk) disable iff (!presetn) // R7
        pd_q != `PD_NORMAL |=> !ladder_connect && !ladder_src_vdd)
        else $error("ladder connected in power-down");
    a_pd_amp_off: assert property (@(posedge pclk) disable iff (!presetn) // R8
        pd_q != `PD_NORMAL |=> !amp_enable
                  && powerdown_load_select == $past(pd_q))
        else $error("amplifier on in power-down");
    a_gain_unity: assert property (@(posedge pclk) disable iff (!presetn) // R9
        !src_is_pin(src_q) |=> !amp_gain2)
        else $error("gain two with rail reference");
    a_gain_sources: assert property (@(posedge pclk) disable iff (!presetn) // R10
        $changed(gain_q) |-> $past(bor_w || reload_w || commit_w))
        else $error("gain changed without a permitted event");
    a_ack_commit: assert property (@(posedge pclk) disable iff (!presetn) // R12
        s_ack_commit |=> code_q == $past(stg_code_q)
                         && pend_q == $past(stg_ctrl || stg_code)
                         ##1 ladder_code == $past(code_q))
        else $error("code not taken at acknowledge edge");
    a_gc_reload: assert property (@(posedge pclk) disable iff (!presetn) // R13
        gc_w |=> code_q == $past(nv_code_q) && pd_q == $past(nv_pd_q)
                 && gain_q == $past(nv_gain_q))
        else $error("general call did not reload stored state");
    a_ready_delay: assert property (@(posedge pclk) disable iff (!presetn) // R15
        por_w |=> por_flag_q && !ready_w ##1 !serial_ready)
        else $error("serial access open before reset delay");
endmodule : dac_ctrl
`default_nettype wire

// ===== scl_master.sv
`timescale 1ns/1ps
`default_nettype none
module scl_master (
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic [3:0] low_len,
    output var  logic       scl_pin
);
    logic [3:0] cnt_q;
    initial begin
        scl_pin = 1'b1;
        cnt_q   = 4'h0;
    end
    // The master drives the line high when idle; one low pulse ends an ack.
    always @(posedge pclk) begin
        if (go) begin
            scl_pin <= 1'b0;
            cnt_q   <= low_len;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            scl_pin <= 1'b1;
        end
    end
endmodule : scl_master
`default_nettype wire

// ===== dac_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_bench;
    import dac_ctrl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, supply_ok_pin, go;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, serial_ready, scl_pin;
    logic        ladder_connect, ladder_src_vdd, ladder_src_pin_buf;
    logic        ladder_src_pin_unbuf, amp_enable, amp_gain2;
    logic [3:0]  low_len;
    logic [11:0] ladder_code, code;
    logic [1:0]  powerdown_load_select, pd, src;
    logic        gain;
    logic [5:0]  m;
    integer      seed;
    int          error_cnt, cmp_count;

    dac_ctrl #(.RES_BITS(12), .POR_DELAY_CYCLES(8)) dac_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_ok_pin(supply_ok_pin),
        .scl_pin(scl_pin), .ladder_code(ladder_code),
        .ladder_connect(ladder_connect), .ladder_src_vdd(ladder_src_vdd),
        .ladder_src_pin_buf(ladder_src_pin_buf),
        .ladder_src_pin_unbuf(ladder_src_pin_unbuf),
        .amp_enable(amp_enable), .amp_gain2(amp_gain2),
        .powerdown_load_select(powerdown_load_select),
        .serial_ready(serial_ready));
    scl_master scl_master_inst (.pclk(pclk), .go(go), .low_len(low_len),
        .scl_pin(scl_pin));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    function automatic logic [5:0] exp_out(logic [1:0] p, logic [1:0] s,
                                            logic g);
        logic on;
        on = (p == 2'b00);
        return {on, on & ~s[1], on & (s == 2'b11), on & (s == 2'b10), on,
                on & g & s[1]};
    endfunction : exp_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Master holds every qualifier until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wait_ready();
        do begin
            apb(1'b0, 8'h10, 32'h0);
        end while (rd[1] !== 1'b1);
    endtask : wait_ready

    task automatic pulse(input logic [3:0] len);
        @(posedge pclk);
        go <= 1'b1; low_len <= len;
        @(posedge pclk);
        go <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : pulse

    task automatic chk_out(input logic [1:0] p, input logic [1:0] s,
                           input logic g, input logic [11:0] c);
        m = (p == 2'b00) ? 6'h3f : 6'h3e;
        chk({26'h0, m & {ladder_connect, ladder_src_vdd, ladder_src_pin_buf,
             ladder_src_pin_unbuf, amp_enable, amp_gain2}},
            {26'h0, m & exp_out(p, s, g)});
        chk({20'h0, ladder_code}, {20'h0, c});
        chk({30'h0, powerdown_load_select}, {30'h0, p});
    endtask : chk_out

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        seed = 32'h0900;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
        pwdata = 32'h0; go = 1'b0; low_len = 4'h3; supply_ok_pin = 1'b1;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_ready();
        chk({31'h0, rd[0]}, 32'h1);
        chk_out(2'b00, 2'b00, 1'b0, 12'h0);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test reset and map done");
        code = 12'h0;
        for (int i = 0; i < 16; i++) begin
            pd = i[1:0]; src = i[3:2]; gain = 1'($random(seed));
            apb(1'b1, 8'h00, {27'h0, gain, src, pd});
            apb(1'b1, 8'h04, {20'h0, (i == 15) ? 12'hfff : 12'($random(seed))});
            chk({20'h0, ladder_code}, {20'h0, code});
            apb(1'b0, 8'h04, 32'h0);
            chk(rd, {20'h0, code});
            apb(1'b0, 8'h10, 32'h0);
            chk({31'h0, rd[2]}, 32'h1);
            apb(1'b1, 8'h04, {20'h0, (i == 15) ? 12'hfff : 12'(i * 273)});
            pulse(i[0] ? 4'hc : 4'h3);
            code = (i == 15) ? 12'hfff : 12'(i * 273);
            chk_out(pd, src, gain, code);
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, {27'h0, gain, src, pd});
        end
        $display("test modes and codes done");
        apb(1'b1, 8'h08, {27'h0, 1'b1, 2'b11, 2'b00});
        apb(1'b1, 8'h0c, 32'h0abc);
        apb(1'b1, 8'h14, 32'h1);
        repeat (4) @(posedge pclk);
        chk_out(2'b00, 2'b11, 1'b1, 12'habc);
        $display("test general call done");
        apb(1'b1, 8'h08, {27'h0, 1'b1, 2'b10, 2'b01});
        apb(1'b1, 8'h0c, 32'h0123);
        @(posedge pclk);
        supply_ok_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        chk_out(2'b11, 2'b00, 1'b0, 12'h0);
        chk({31'h0, serial_ready}, 32'h0);
        // A write while the supply is down must not reach the stored code.
        apb(1'b1, 8'h0c, 32'h0fff);
        supply_ok_pin <= 1'b1;
        wait_ready();
        chk({31'h0, rd[0]}, 32'h1);
        chk_out(2'b01, 2'b10, 1'b1, 12'h123);
        $display("test supply cycle done");
        report_and_stop();
    end
endmodule : dac_ctrl_bench
`default_nettype wire
